// ==== core/ignition_defs.vh ====
// Summary of operation
// - heat request start asserts pilot valve, and spark unless lower flame flag is true, opening a trial.
// - default trial with no flame stops spark after 90 seconds.
// - spark drops at once when lower flame flag is true during trial.
// - main valve opens only on higher flame flag, never lower alone.
// - spark may return if lower flag drops, while trial time remains.
// - whole trial including spark restarts never exceeds configured trial time.
// - short stabilization interval after main valve opens before run mode.
// - run mode watches flame; on loss pilot and main valves close.
// - no flame by trial end turns spark and pilot off.
// - after failed trial wait five minutes off, then retry if heat remains.
// - trial and wait repeat without lockout until flame or heat ends.
// - removing heat or reset cancels pending wait; fresh trial can start.
// - return to idle after heat absent 30 seconds following a shutoff.
// - heat removal in any state turns spark, pilot and main off.
// - settings freeze once lock link pulled or tenth heat request begins.
`ifndef IGNITION_DEFS_VH
`define IGNITION_DEFS_VH
`define CLK_HZ           20000000
`define TICK_HZ          10
`define TICK_DIV         (`CLK_HZ / `TICK_HZ)
`define TRIAL_SEC        90
`define TRIAL_TICKS      (`TRIAL_SEC * `TICK_HZ)
`define WAIT_MIN         5
`define WAIT_TICKS       (`WAIT_MIN * 60 * `TICK_HZ)
`define IDLE_SEC         30
`define IDLE_TICKS       (`IDLE_SEC * `TICK_HZ)
`define STAB_TICKS       20
`define LOCK_COUNT       10
`define CFG_WIDTH        2
`define CFG_RESET        2'h0
`endif

// ==== core/tick_divider.v ====
`timescale 1ns/10ps
`include "ignition_defs.vh"
module tick_divider #(
  parameter DIV = `TICK_DIV
) (
  input  wire sys_clk,
  input  wire sys_rst,
  output reg  tick
);
  reg [31:0] cnt_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg >= DIV - 1) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule // tick_divider

// ==== core/ignition_sequencer.v ====
`timescale 1ns/10ps
`include "ignition_defs.vh"
module ignition_sequencer #(
  parameter TICK_DIV    = `TICK_DIV,
  parameter TRIAL_TICKS = `TRIAL_TICKS,
  parameter WAIT_TICKS  = `WAIT_TICKS,
  parameter IDLE_TICKS  = `IDLE_TICKS,
  parameter STAB_TICKS  = `STAB_TICKS
) (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       heat_request,
  input  wire       flame_low,
  input  wire       flame_high,
  input  wire       settings_lock_link,
  input  wire [1:0] config_switches,
  output reg        spark_drive,
  output reg        pilot_valve_drive,
  output reg        main_valve_drive,
  output reg  [1:0] active_config,
  output reg        config_locked
);
  // ***************************************************
  // states
  // ***************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_TRIAL = 3'h1;
  localparam [2:0] ST_STAB  = 3'h2;
  localparam [2:0] ST_RUN   = 3'h3;
  localparam [2:0] ST_WAIT  = 3'h4;
  localparam [2:0] ST_OFF   = 3'h5;

  localparam integer LOCK_LAST = `LOCK_COUNT - 1;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] time_reg;
  reg  [15:0] time_next;
  reg  [15:0] idle_reg;
  reg  [15:0] idle_next;
  reg  [15:0] guard_reg;
  reg  [15:0] guard_next;
  reg  [3:0]  calls_reg;
  reg  [3:0]  calls_next;
  reg         locked_next;
  reg  [1:0]  config_next;
  reg         heat_prev_reg;
  reg         spark_next;
  reg         pilot_next;
  reg         main_next;
  wire        tick;
  wire        heat_rise;
  wire        call_start;
  wire        idle_done;
  wire        guard_over;
  wire        in_idle;
  wire        in_trial;

  // ***************************************************
  // helpers
  // ***************************************************
  // interval check shared by every timer
  function reached;
    input [15:0] count;
    input [15:0] limit;
    begin
      reached = (count >= limit);
    end
  endfunction

  // one tick step of a timer, held at its ceiling
  function [15:0] step;
    input [15:0] count;
    input [15:0] limit;
    input        en;
    begin
      if (en && count < limit)
        step = count + 16'h1;
      else
        step = count;
    end
  endfunction

  // ***************************************************
  // tick prescaler
  // ***************************************************
  tick_divider #(
    .DIV (TICK_DIV)
  ) u_div (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // ***************************************************
  // state decode
  // ***************************************************
  assign in_idle  = (state_reg == ST_IDLE);
  assign in_trial = (state_reg == ST_TRIAL);

  // ***************************************************
  // call for heat edge
  // ***************************************************
  // starts high: a request already present at reset release
  // must drop once before it counts as a new call
  always @(posedge sys_clk) begin
    if (sys_rst)
      heat_prev_reg <= 1'b1;
    else
      heat_prev_reg <= heat_request;
  end

  assign heat_rise  = heat_request & ~heat_prev_reg;
  assign call_start = heat_rise & in_idle;

  // ***************************************************
  // heat-off timer
  // ***************************************************
  // counts only while the request stays away
  always @* begin
    if (heat_request)
      idle_next = 16'h0;
    else
      idle_next = step(idle_reg, IDLE_TICKS[15:0], tick);
  end

  assign idle_done = reached(idle_reg, IDLE_TICKS[15:0]);

  always @(posedge sys_clk) begin
    if (sys_rst)
      idle_reg <= 16'h0;
    else
      idle_reg <= idle_next;
  end

  // ***************************************************
  // trial guard
  // ***************************************************
  // separate age of the running trial; spark and pilot are cut
  // here even if the sequence itself ever overstays a trial
  always @* begin
    if (in_trial)
      guard_next = step(guard_reg, TRIAL_TICKS[15:0], tick);
    else
      guard_next = 16'h0;
  end

  assign guard_over = reached(guard_next, TRIAL_TICKS[15:0]);

  always @(posedge sys_clk) begin
    if (sys_rst)
      guard_reg <= 16'h0;
    else
      guard_reg <= guard_next;
  end

  // ***************************************************
  // sequence
  // ***************************************************
  always @* begin
    state_next = state_reg;
    time_next  = tick ? time_reg + 16'h1 : time_reg;
    spark_next = 1'b0;
    pilot_next = 1'b0;
    main_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        time_next = 16'h0;
        if (heat_rise) begin
          state_next = ST_TRIAL;
          spark_next = ~flame_low;
          pilot_next = 1'b1;
        end
      end
      ST_TRIAL: begin
        if (reached(time_next, TRIAL_TICKS[15:0])) begin
          state_next = ST_WAIT;
          time_next  = 16'h0;
        end else if (flame_high) begin
          state_next = ST_STAB;
          time_next  = 16'h0;
          pilot_next = 1'b1;
          main_next  = 1'b1;
        end else begin
          pilot_next = 1'b1;
          spark_next = ~flame_low;
        end
      end
      ST_STAB: begin
        if (!flame_low) begin
          state_next = ST_OFF;
        end else begin
          pilot_next = 1'b1;
          main_next  = 1'b1;
          if (reached(time_next, STAB_TICKS[15:0]))
            state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!flame_low) begin
          state_next = ST_OFF;
        end else begin
          pilot_next = 1'b1;
          main_next  = 1'b1;
        end
      end
      ST_WAIT: begin
        if (reached(time_next, WAIT_TICKS[15:0])) begin
          state_next = ST_TRIAL;
          time_next  = 16'h0;
          pilot_next = 1'b1;
          spark_next = ~flame_low;
        end
      end
      ST_OFF: begin
        time_next = 16'h0;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!heat_request) begin
      spark_next = 1'b0;
      pilot_next = 1'b0;
      main_next  = 1'b0;
      if (!in_idle)
        state_next = ST_OFF;
      if (idle_done)
        state_next = ST_IDLE;
    end
  end

  // ***************************************************
  // state registers
  // ***************************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      time_reg  <= 16'h0;
    end else begin
      state_reg <= state_next;
      time_reg  <= time_next;
    end
  end

  // ***************************************************
  // output drives
  // ***************************************************
  // every drive comes straight from a flip-flop
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      spark_drive       <= 1'b0;
      pilot_valve_drive <= 1'b0;
      main_valve_drive  <= 1'b0;
    end else begin
      spark_drive       <= spark_next & ~guard_over;
      pilot_valve_drive <= pilot_next & ~guard_over;
      main_valve_drive  <= main_next;
    end
  end

  // ***************************************************
  // settings lock
  // ***************************************************
  always @* begin
    calls_next  = calls_reg;
    locked_next = config_locked;
    config_next = active_config;
    if (!config_locked) begin
      config_next = config_switches;
      if (!settings_lock_link) begin
        locked_next = 1'b1;
      end else if (call_start) begin
        calls_next = calls_reg + 4'h1;
        if (calls_reg == LOCK_LAST[3:0])
          locked_next = 1'b1;
      end
    end
  end

  // once locked nothing but reset reopens the settings
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      calls_reg     <= 4'h0;
      config_locked <= 1'b0;
      active_config <= `CFG_RESET;
    end else begin
      calls_reg     <= calls_next;
      config_locked <= locked_next;
      active_config <= config_next;
    end
  end
endmodule // ignition_sequencer

// ==== dv/ignition_checker.sv ====
`timescale 1ns/10ps
module ignition_checker #(
  parameter TICK_DIV    = 4,
  parameter TRIAL_TICKS = 9
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire heat_request,
  input wire flame_low,
  input wire flame_high,
  input wire spark_drive,
  input wire pilot_valve_drive,
  input wire main_valve_drive
);
  int trial_len_reg;
  always @(posedge sys_clk)
    trial_len_reg <= (sys_rst || !pilot_valve_drive || main_valve_drive) ? 0 : trial_len_reg + 1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_trial_end;
    $fell(pilot_valve_drive) && !$past(main_valve_drive);
  endsequence
  chk_start_pair: assert property ($rose(pilot_valve_drive) |-> spark_drive) else $error("pilot without spark");
  chk_spark_stop: assert property (spark_drive && flame_low |=> !spark_drive) else $error("spark kept");
  chk_main_high: assert property ($rose(main_valve_drive) |-> $past(flame_high)) else $error("main early");
  chk_main_pilot: assert property (main_valve_drive |-> pilot_valve_drive) else $error("main alone");
  chk_flame_loss: assert property (main_valve_drive && !flame_low |=> !pilot_valve_drive && !main_valve_drive)
    else $error("flame loss kept");
  chk_heat_off: assert property (!heat_request |=> !(spark_drive || pilot_valve_drive || main_valve_drive))
    else $error("heat off kept");
  chk_trial_len: assert property (trial_len_reg <= TRIAL_TICKS * TICK_DIV + TICK_DIV) else $error("trial long");
  chk_wait_off: assert property (s_trial_end |-> !pilot_valve_drive [*8]) else $error("no wait");
endmodule // ignition_checker
bind ignition_sequencer ignition_checker #(.TICK_DIV(TICK_DIV), .TRIAL_TICKS(TRIAL_TICKS)) i_ignition_checker (.*);

// ==== dv/flame_model.sv ====
`timescale 1ns/10ps
module flame_model (
  input  wire       sys_clk,
  input  wire       pilot_valve_drive,
  input  wire       gas_on,
  output reg        flame_low,
  output reg        flame_high
);
  reg [2:0] age_reg;
  initial begin
    age_reg = 3'h0;
    flame_low = 1'b0;
    flame_high = 1'b0;
  end
  // lower flag first, higher two cycles later
  always @(posedge sys_clk) begin
    age_reg <= (gas_on && pilot_valve_drive) ? ((age_reg == 3'h7) ? age_reg : age_reg + 3'h1) : 3'h0;
    flame_low <= gas_on && pilot_valve_drive && age_reg >= 3'h2;
    flame_high <= gas_on && pilot_valve_drive && age_reg >= 3'h4;
  end
endmodule // flame_model

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic       sys_clk, sys_rst, heat_request, gas_on, settings_lock_link;
  logic [1:0] config_switches;
  wire  [1:0] active_config;
  wire        flame_low, flame_high, spark_drive, pilot_valve_drive, main_valve_drive, config_locked;
  wire  [2:0] outs = {spark_drive, pilot_valve_drive, main_valve_drive};
  int         n_mismatch, checks, cyc, n;
  ignition_sequencer #(.TICK_DIV(4), .TRIAL_TICKS(9), .WAIT_TICKS(30), .IDLE_TICKS(3), .STAB_TICKS(2))
    i_ignition_sequencer (.*);
  flame_model i_flame_model (.*);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results;
    end
  end
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task wait_for(input logic [2:0] v);
    n = 0;
    while (outs !== v && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task t_lock;
    check({1'b0, active_config}, 3'h2);
    settings_lock_link = 0;
    tick(2);
    config_switches = 2'h1;
    settings_lock_link = 1;
    tick(2);
    check({config_locked, active_config}, 3'h6);
    $display("test lock done");
  endtask
  task t_fail;
    heat_request = 1;
    tick(2);
    check(outs, 3'h6);
    wait_for(3'h0);
    check(3'(n >= 30 && n <= 38), 3'h1);
    wait_for(3'h6);
    check(3'(n >= 116 && n <= 124), 3'h1);
    heat_request = 0;
    tick(2);
    check(outs, 3'h0);
    tick(20);
    $display("test fail done");
  endtask
  task t_light;
    gas_on = 1;
    heat_request = 1;
    wait_for(3'h2);
    check(3'(n < 8), 3'h1);
    wait_for(3'h3);
    check(3'(n < 12), 3'h1);
    tick(12);
    gas_on = 0;
    tick(2);
    check(outs, 3'h0);
    heat_request = 0;
    tick(20);
    $display("test light done");
  endtask
  task t_cancel;
    heat_request = 1;
    wait_for(3'h0);
    heat_request = 0;
    tick(20);
    heat_request = 1;
    tick(2);
    check(outs, 3'h6);
    heat_request = 0;
    $display("test cancel done");
  endtask
  initial begin
    sys_rst = 1;
    heat_request = 0;
    gas_on = 0;
    settings_lock_link = 1;
    config_switches = 2'h2;
    tick(4);
    sys_rst = 0;
    tick(2);
    t_lock;
    t_fail;
    t_light;
    t_cancel;
    results;
  end
endmodule // tb
